/* core/dsp_interrupt_controller.v */
// Summary of operation
// - Eleven prioritized sources plus reset, each dispatched to a fixed vector.
// - Vectors: reset 0, power-down 2C, then 04..24 by four, timer 28 lowest.
// - Four dedicated external requests plus two from reconfigured serial port one.
// - Internal requests from timer, byte DMA, both serial ports, software, power-down.
// - Configurable input and both alternate-port inputs selectable edge or level.
// - Level inputs always level; edge input always edge.
// - Requests ANDed with mask; highest surviving request selected.
// - Reset and power-down unmaskable; all others individually maskable.
// - Control bit picks nested preemption or sequential servicing.
// - Control register holds nesting enable and three edge/level selects.
// - Mask write blocks all interrupts for one following cycle.
// - Edge input pending state settable and clearable by software.
// - Write-only force/clear register sets or clears pending requests.
// - Status pushed on entry, popped on return, twelve-deep shared stack.
// - Global enable/disable gates all servicing, power-down included.
// - Global servicing enable is on after reset.
// - Reset empties stack, masks every source except power-down, clears mode status.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module dsp_interrupt_controller #(
  parameter STAT_W = 16
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cfgExtRequestN,
  input wire levelRequestAN,
  input wire levelRequestBN,
  input wire edgeRequestN,
  input wire altPortRequestAN,
  input wire altPortRequestBN,
  input wire timerEvent,
  input wire byteDmaEvent,
  input wire sport0TxEvent,
  input wire sport0RxEvent,
  input wire sport1TxEvent,
  input wire sport1RxEvent,
  input wire powerDownEvent,
  input wire globalIrqEnableInstr,
  input wire globalIrqDisableInstr,
  input wire [STAT_W-1:0] statusIn,
  input wire serviceReturn,
  output reg irqTake,
  output reg [13:0] irqVector,
  output reg [STAT_W-1:0] statusOut,
  output wire [3:0] stackLevel,
  output wire irq
);
  // Two-flop synchronisers for the six pins, active low
  reg [5:0] pinS1_q;
  reg [5:0] pinS2_q;
  reg [5:0] pinPrev_q;
  wire [5:0] pinRaw = ~{altPortRequestBN, altPortRequestAN, edgeRequestN,
    levelRequestBN, levelRequestAN, cfgExtRequestN};
  always @(posedge clk) begin
    if (rst) begin
      pinS1_q <= 6'h00;
      pinS2_q <= 6'h00;
      pinPrev_q <= 6'h00;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinPrev_q <= pinS2_q;
    end
  end
  wire [5:0] pinRise = pinS2_q & ~pinPrev_q;

  reg [10:0] mask_q;
  reg [6:0] ctrl_q;
  reg [10:0] pend_q;
  reg [10:0] inSvc_q;
  reg maskBlock_q;
  reg [2:0] istat_q;
  reg [2:0] ien_q;
  reg [STAT_W-1:0] stack_q [0:`STACK_DEPTH-1];
  reg [3:0] sp_q;

  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & penable & ~pwrite;
  wire hit = (paddr[11:2] <= `OFF_STACK >> 2) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  wire wrMask = apbWr && paddr == `OFF_MASK;
  wire wrCtrl = apbWr && paddr == `OFF_CTRL;
  wire wrForce = apbWr && paddr == `OFF_FORCE;
  wire wrIclr = apbWr && paddr == `OFF_ICLR;
  wire wrIen = apbWr && paddr == `OFF_IEN;

  wire altEn = ctrl_q[`CTL_ALT_EN];
  // Per-source raw request, level sources follow the pin directly
  wire cfgReq = ctrl_q[`CTL_CFG_EDGE] ? 1'b0 : pinS2_q[0];
  wire altAReq = ctrl_q[`CTL_ALTA_EDGE] ? 1'b0 : pinS2_q[4];
  wire altBReq = ctrl_q[`CTL_ALTB_EDGE] ? 1'b0 : pinS2_q[5];
  reg [10:0] levelReq;
  reg [10:0] edgeSet;
  always @* begin
    levelReq = 11'h000;
    edgeSet = 11'h000;
    levelReq[`SRC_CFG] = cfgReq;
    levelReq[`SRC_LVLA] = pinS2_q[1];
    levelReq[`SRC_LVLB] = pinS2_q[2];
    levelReq[`SRC_SP1RX] = altEn & altAReq;
    levelReq[`SRC_SP1TX] = altEn & altBReq;
    edgeSet[`SRC_CFG] = ctrl_q[`CTL_CFG_EDGE] & pinRise[0];
    edgeSet[`SRC_EDGE] = pinRise[3];
    edgeSet[`SRC_SP1RX] = altEn ? ctrl_q[`CTL_ALTA_EDGE] & pinRise[4]
      : sport1RxEvent;
    edgeSet[`SRC_SP1TX] = altEn ? ctrl_q[`CTL_ALTB_EDGE] & pinRise[5]
      : sport1TxEvent;
    edgeSet[`SRC_TIMER] = timerEvent;
    edgeSet[`SRC_BYTE_DMA_PORT] = byteDmaEvent;
    edgeSet[`SRC_SP0RX] = sport0RxEvent;
    edgeSet[`SRC_SP0TX] = sport0TxEvent;
    edgeSet[`SRC_PWD] = powerDownEvent;
  end

  wire [10:0] req = pend_q | levelReq;
  // Power-down bypasses the mask
  wire [10:0] effMask = mask_q | (11'h001 << `SRC_PWD);
  wire [10:0] live = req & effMask;

  // Highest set index wins; nesting allows only a higher level than active
  reg [3:0] winIdx;
  reg winValid;
  reg [3:0] actIdx;
  reg actValid;
  integer i;
  always @* begin
    winIdx = 4'd0;
    winValid = 1'b0;
    actIdx = 4'd0;
    actValid = 1'b0;
    for (i = 0; i < `NSRC; i = i + 1) begin
      if (live[i]) begin
        winIdx = i[3:0];
        winValid = 1'b1;
      end
      if (inSvc_q[i]) begin
        actIdx = i[3:0];
        actValid = 1'b1;
      end
    end
  end
  wire nestOk = ctrl_q[`CTL_NEST] ? (!actValid || winIdx > actIdx)
    : !actValid;
  wire stackFull = sp_q == `STACK_DEPTH;
  // A return in the same cycle wins; push and pop never share an edge
  wire take = winValid && nestOk && ctrl_q[`CTL_GIE] && !maskBlock_q
    && !stackFull && !serviceReturn;

  function [13:0] vecOf;
    input [3:0] idx;
    begin
      if (idx == `SRC_PWD)
        vecOf = `VEC_PWD;
      else if (idx == `SRC_TIMER)
        vecOf = `VEC_TIMER;
      else
        vecOf = `VEC_CFG + (4'd9 - idx) * `VEC_STEP;
    end
  endfunction

  wire [10:0] takeBit = take ? (11'h001 << winIdx) : 11'h000;
  wire [10:0] forceSet = wrForce ? pwdata[10:0] : 11'h000;
  wire [10:0] forceClr = wrForce ? pwdata[`FRC_CLR_LSB+10:`FRC_CLR_LSB]
    : 11'h000;
  // Set by hardware wins over software clear; vectoring clears it
  wire [10:0] pend_d = ((pend_q & ~forceClr & ~takeBit) | edgeSet
    | forceSet);
  wire doPop = serviceReturn && sp_q != 4'd0;
  reg [10:0] retBit;
  always @* begin
    retBit = 11'h000;
    if (doPop && actValid)
      retBit = 11'h001 << actIdx;
  end
  wire underflow = serviceReturn && sp_q == 4'd0;
  wire overflow = winValid && nestOk && ctrl_q[`CTL_GIE] && !maskBlock_q
    && stackFull;

  always @(posedge clk) begin
    if (rst) begin
      mask_q <= `MASK_RST;
      ctrl_q <= `CTRL_RST;
      pend_q <= 11'h000;
      inSvc_q <= 11'h000;
      maskBlock_q <= 1'b0;
      sp_q <= 4'd0;
      irqTake <= 1'b0;
      irqVector <= `VEC_RESET;
      statusOut <= {STAT_W{1'b0}};
      istat_q <= 3'h0;
      ien_q <= 3'h0;
    end else begin
      pend_q <= pend_d;
      inSvc_q <= (inSvc_q & ~retBit) | takeBit;
      maskBlock_q <= wrMask;
      if (wrMask)
        mask_q <= pwdata[10:0];
      if (wrCtrl)
        ctrl_q <= pwdata[6:0];
      if (globalIrqEnableInstr)
        ctrl_q[`CTL_GIE] <= 1'b1;
      else if (globalIrqDisableInstr)
        ctrl_q[`CTL_GIE] <= 1'b0;
      irqTake <= take;
      if (take)
        irqVector <= vecOf(winIdx);
      if (take) begin
        stack_q[sp_q] <= statusIn;
        sp_q <= sp_q + 4'd1;
      end else if (doPop) begin
        statusOut <= stack_q[sp_q-4'd1];
        sp_q <= sp_q - 4'd1;
      end
      if (wrIen)
        ien_q <= pwdata[2:0];
      istat_q <= (istat_q & ~(wrIclr ? pwdata[2:0] : 3'h0))
        | {underflow, overflow, take};
    end
  end
  assign stackLevel = sp_q;
  assign irq = |(istat_q & ien_q);

  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    if (apbRd) begin
      case (paddr)
        `OFF_MASK: rd = {21'h0, mask_q};
        `OFF_CTRL: rd = {25'h0, ctrl_q};
        `OFF_PEND: rd = {21'h0, req};
        `OFF_STAT: rd = {21'h0, inSvc_q};
        `OFF_ISTAT: rd = {29'h0, istat_q};
        `OFF_IEN: rd = {29'h0, ien_q};
        `OFF_STACK: rd = {28'h0, sp_q};
        default: rd = 32'h0000_0000; // Force and clear read as zero
      endcase
    end
  end
  assign prdata = rd;
endmodule // dsp_interrupt_controller
`default_nettype wire

/* core/irq_ctrl_defines.vh */
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH
// APB register byte offsets
`define OFF_MASK 12'h000
`define OFF_CTRL 12'h004
`define OFF_FORCE 12'h008
`define OFF_PEND 12'h00C
`define OFF_STAT 12'h010
`define OFF_ISTAT 12'h014
`define OFF_ICLR 12'h018
`define OFF_IEN 12'h01C
`define OFF_STACK 12'h020
// Source indices, 0 is lowest priority
`define SRC_TIMER 0
`define SRC_SP1RX 1
`define SRC_SP1TX 2
`define SRC_BYTE_DMA_PORT 3
`define SRC_EDGE 4
`define SRC_SP0RX 5
`define SRC_SP0TX 6
`define SRC_LVLA 7
`define SRC_LVLB 8
`define SRC_CFG 9
`define SRC_PWD 10
`define NSRC 11
// Vector addresses
`define VEC_RESET 14'h0000
`define VEC_PWD 14'h002C
`define VEC_CFG 14'h0004
`define VEC_STEP 14'h0004
`define VEC_TIMER 14'h0028
// Control register fields
`define CTL_CFG_EDGE 0
`define CTL_ALTB_EDGE 1
`define CTL_ALTA_EDGE 2
`define CTL_NEST 4
`define CTL_ALT_EN 5
`define CTL_GIE 6
// Reset values
`define MASK_RST 11'h000
`define CTRL_RST 7'h40
// Force register: low 11 bits force, bits 26:16 clear
`define FRC_CLR_LSB 16
// Interrupt status bits
`define EV_TAKEN 0
`define EV_OVF 1
`define EV_UNF 2
`define STACK_DEPTH 12
`endif

/* sim/irq_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic globalIrqEnableInstr,
  input wire logic globalIrqDisableInstr,
  input wire logic serviceReturn,
  input wire logic irqTake,
  input wire logic [13:0] irqVector,
  input wire logic [3:0] stackLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel & penable;
  property p_rst;
    disable iff (1'h0) rst |=> stackLevel == 4'h0 && !irqTake;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_vec;
    irqTake |-> irqVector[1:0] == 2'h0 && irqVector inside {[14'h4:14'h2C]};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_push;
    irqTake |-> stackLevel == $past(stackLevel) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("no push");
  property p_max;
    stackLevel <= 4'hC;
  endproperty
  a_max: assert property (p_max) else $error("stack too deep");
  // Take seen two edges on would come from the blocked cycle
  property p_mblk;
    acc && pwrite && paddr == 12'h000 |-> ##2 !irqTake;
  endproperty
  a_mblk: assert property (p_mblk) else $error("mask block");
  property p_gie;
    globalIrqDisableInstr && !globalIrqEnableInstr |-> ##2 !irqTake;
  endproperty
  a_gie: assert property (p_gie) else $error("take when off");
  property p_frc;
    acc && !pwrite && paddr == 12'h008 |-> prdata == 32'h0;
  endproperty
  a_frc: assert property (p_frc) else $error("force readable");
  property p_pop;
    serviceReturn && stackLevel != 4'h0 |=>
      irqTake || stackLevel == $past(stackLevel) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("no pop");
endmodule // irq_ctrl_props
`default_nettype wire

/* sim/irq_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_pin_model (
  input wire logic clk,
  input wire logic [5:0] req,
  output logic [5:0] pinN = 6'h3F
);
  // Pins are active low and idle high; no pull-down glitches modelled
  always @(posedge clk) pinN <= ~req;
endmodule // irq_pin_model
`default_nettype wire

/* sim/dsp_interrupt_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module dsp_interrupt_controller_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, serr;
  logic pready, pslverr, irqTake, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [9:0] c = 0;
  logic [5:0] req = 0, pinN;
  logic [15:0] statusOut;
  logic [13:0] irqVector;
  logic [3:0] stackLevel;
  int num_errors = 0, cmp_count = 0;
  always #5 clk = ~clk;
  irq_pin_model PIN (.clk, .req, .pinN);
  dsp_interrupt_controller DUT (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cfgExtRequestN(pinN[0]),
    .levelRequestAN(pinN[1]), .levelRequestBN(pinN[2]),
    .edgeRequestN(pinN[3]), .altPortRequestAN(pinN[4]),
    .altPortRequestBN(pinN[5]), .timerEvent(c[0]), .byteDmaEvent(c[1]),
    .sport0TxEvent(c[2]), .sport0RxEvent(c[3]), .sport1TxEvent(c[4]),
    .sport1RxEvent(c[5]), .powerDownEvent(c[6]), .serviceReturn(c[7]),
    .globalIrqEnableInstr(c[8]), .globalIrqDisableInstr(c[9]),
    .statusIn(16'hA5A5), .irqTake, .irqVector, .statusOut, .stackLevel,
    .irq);
  task chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  // Extra edge lets the pulse's effect land before the caller samples
  task pulse(input int b);
    @(posedge clk);
    c[b] <= 1'h1;
    @(posedge clk);
    c[b] <= 1'h0;
    @(posedge clk);
  endtask
  task take(input logic [13:0] v);
    int i;
    for (i = 0; i < 50 && irqTake !== 1'h1; i++) @(posedge clk);
    chk("take", 1, irqTake);
    chk("vector", v, irqVector);
  endtask
  task conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd("mask", `OFF_MASK, 32'h0);
    rd("ctrl", `OFF_CTRL, 32'h40);
    rd("force", `OFF_FORCE, 32'h0);
    rd("unmapped", 12'h040, 32'h0);
    chk("slverr", 1, serr);
    chk("depth", 0, stackLevel);
    $display("reset test done");
    apb(1'h1, `OFF_IEN, 32'h1);
    apb(1'h1, `OFF_MASK, 32'h10);
    req <= 6'h08;
    take(14'h0018);
    req <= 6'h00;
    chk("depth", 1, stackLevel);
    chk("irq", 1, irq);
    rd("pend", `OFF_PEND, 32'h0);
    rd("istat", `OFF_ISTAT, 32'h1);
    apb(1'h1, `OFF_ICLR, 32'h1);
    @(posedge clk);
    chk("irq", 0, irq);
    pulse(7);
    chk("status", 16'hA5A5, statusOut);
    chk("depth", 0, stackLevel);
    $display("edge test done");
    apb(1'h1, `OFF_MASK, 32'h0);
    apb(1'h1, `OFF_FORCE, 32'h11);
    rd("pend", `OFF_PEND, 32'h11);
    apb(1'h1, `OFF_FORCE, 32'h100000);
    rd("pend", `OFF_PEND, 32'h1);
    apb(1'h1, `OFF_FORCE, 32'h10);
    apb(1'h1, `OFF_MASK, 32'h11);
    take(14'h0018);
    pulse(7);
    take(14'h0028);
    pulse(7);
    $display("priority test done");
    apb(1'h1, `OFF_MASK, 32'h0);
    pulse(6);
    take(14'h002C);
    pulse(7);
    pulse(9);
    apb(1'h1, `OFF_FORCE, 32'h1);
    apb(1'h1, `OFF_MASK, 32'h1);
    repeat (10) @(posedge clk);
    chk("depth", 0, stackLevel);
    pulse(8);
    take(14'h0028);
    pulse(7);
    $display("global test done");
    apb(1'h1, `OFF_CTRL, 32'h50);
    apb(1'h1, `OFF_MASK, 32'h11);
    apb(1'h1, `OFF_FORCE, 32'h1);
    take(14'h0028);
    apb(1'h1, `OFF_FORCE, 32'h10);
    take(14'h0018);
    chk("depth", 2, stackLevel);
    pulse(7);
    pulse(7);
    chk("depth", 0, stackLevel);
    $display("nesting test done");
    apb(1'h1, `OFF_MASK, 32'h80);
    req <= 6'h02;
    take(14'h000C);
    req <= 6'h00;
    repeat (4) @(posedge clk);
    pulse(7);
    chk("depth", 0, stackLevel);
    $display("level test done");
    conclude;
  end
endmodule // dsp_interrupt_controller_tb_top
bind dsp_interrupt_controller irq_ctrl_props u_props (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .globalIrqEnableInstr,
  .globalIrqDisableInstr, .serviceReturn, .irqTake, .irqVector,
  .stackLevel);
`default_nettype wire
